// File: rtl/pef_top.sv
/*
 * pef_top: two packet event filters for the scale port performance counters,
 * with their select registers on an apb slave.
 * assumes packets and count modes come from logic on pclk; one packet per cycle.
 */
// Functional notes
// - every packet received on the scale port is a candidate event
// - inbound requests and responses to our own requests are both candidates
// - event fires only when every group matches; alternatives within group OR
// - length select 111 any, 000..100 exact size code, 101/110 reserved
// - attribute 1111 matches all, otherwise exact match required
// - source node all ones matches all, otherwise exact match required
// - port bit 14 enables port zero, bit 15 enables port one
// - request type compared as major, minor and coherency bits
// - response type compared as response type, completion and coherency bits
// - mask bit one removes that type bit from the compare; 7Fh all
// - count mode 10 makes counter add packet length instead of one
`timescale 1ns/1ps
`default_nettype none
module pef_top
    import pef_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // received packets
    input wire logic pkt_valid,
    input wire pef_pkt_t pkt,
    // counter side
    input wire logic [1:0] count_mode0,
    input wire logic [1:0] count_mode1,
    output pef_ev_t ev0,
    output pef_ev_t ev1
);
    // register state
    pef_sel_t sel_q [2];
    pef_sel_t sel_d [2];
    logic [15:0] hits_q [2];
    logic [15:0] hits_d [2];
    pef_pkt_t last_q;
    pef_pkt_t last_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    // event state
    pef_ev_t ev_q [2];
    pef_ev_t ev_d [2];

    logic [1:0] match;
    logic [1:0] mode [2];
    logic setup;
    logic access;
    logic wr;
    logic mapped;
    logic hits_clr;
    logic [31:0] wmask;

    assign mode[0] = count_mode0;
    assign mode[1] = count_mode1;

    // one matcher per counter copy
    for (genvar i = 0; i < 2; i++) begin : g_match
        pef_match u_match (
            .sel(sel_q[i]),
            .pkt(pkt),
            .match(match[i])
        );
    end

    // apb decode
    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        mapped = (paddr == PEF_OFS_SEL0) || (paddr == PEF_OFS_SEL1) ||
                 (paddr == PEF_OFS_HITS) || (paddr == PEF_OFS_LAST);
        wr = access && pwrite && mapped && ce;
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        hits_clr = wr && (paddr == PEF_OFS_HITS);
    end

    // zero wait state: read data is captured in the setup cycle
    assign pready = access && ce;
    assign pslverr = access && ce && !mapped;
    assign prdata = prdata_q;

    // register next values
    always_comb begin
        sel_d[0] = sel_q[0];
        sel_d[1] = sel_q[1];
        prdata_d = prdata_q;
        if (wr && paddr == PEF_OFS_SEL0) begin
            sel_d[0] = pef_sel_t'(((sel_q[0] & ~wmask) | (pwdata & wmask)) & PEF_SEL_WMASK);
        end
        if (wr && paddr == PEF_OFS_SEL1) begin
            sel_d[1] = pef_sel_t'(((sel_q[1] & ~wmask) | (pwdata & wmask)) & PEF_SEL_WMASK);
        end
        if (setup && !pwrite) begin
            unique case (paddr)
                PEF_OFS_SEL0: prdata_d = sel_q[0];
                PEF_OFS_SEL1: prdata_d = sel_q[1];
                PEF_OFS_HITS: prdata_d = {hits_q[1], hits_q[0]};
                PEF_OFS_LAST: prdata_d = {11'h000, last_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q[0] <= pef_sel_t'(PEF_SEL_RESET);
            sel_q[1] <= pef_sel_t'(PEF_SEL_RESET);
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            sel_q[0] <= sel_d[0];
            sel_q[1] <= sel_d[1];
            prdata_q <= prdata_d;
        end
    end

    // event next values
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            // every valid packet, request or response, goes through the matcher
            ev_d[i].hit = pkt_valid && match[i];
            ev_d[i].inc = 8'h00;
            if (pkt_valid && match[i]) begin
                // length mode: size in bytes, code 000 counted as 8
                ev_d[i].inc = (mode[i] == PEF_MODE_LENGTH) ?
                              8'(PEF_LEN_UNIT << pkt.len) : PEF_INC_ONE;
            end
            // a hit in the clearing cycle still counts
            hits_d[i] = hits_clr ? 16'h0000 : hits_q[i];
            if (pkt_valid && match[i]) begin
                hits_d[i] = hits_d[i] + 16'h0001;
            end
        end
        last_d = last_q;
        if (pkt_valid && |match) begin
            last_d = pkt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_q[0] <= '0;
            ev_q[1] <= '0;
            hits_q[0] <= 16'h0000;
            hits_q[1] <= 16'h0000;
            last_q <= '0;
        end else if (ce) begin
            ev_q[0] <= ev_d[0];
            ev_q[1] <= ev_d[1];
            hits_q[0] <= hits_d[0];
            hits_q[1] <= hits_d[1];
            last_q <= last_d;
        end
    end

    // counter ignores inc while hit is low; frozen ce holds the pulse too
    assign ev0 = ev_q[0];
    assign ev1 = ev_q[1];

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_HIT_NEEDS_PKT: assert property (
        $past(ce) && ev_q[0].hit |-> $past(pkt_valid)
    ) else $error("hit without a received packet");

    AST_HIT_ONE_CYCLE: assert property (
        ce && $past(ce) && ev_q[1].hit && !pkt_valid |=> !ev_q[1].hit
    ) else $error("hit longer than one cycle");

    AST_PORT_SELECT: assert property (
        $past(ce) && ev_q[0].hit |->
            $past(pkt.port ? sel_q[0].port[1] : sel_q[0].port[0])
    ) else $error("hit from a disabled port");

    AST_WILDCARD_HIT: assert property (
        ce && pkt_valid && sel_q[0].len == PEF_LEN_ANY &&
        sel_q[0].attr == PEF_ATTR_ANY && sel_q[0].src == PEF_SRC_ANY &&
        sel_q[0].port == 2'h3 && sel_q[0].tmask == PEF_MASK_ALL |=> ev_q[0].hit
    ) else $error("all wildcard select missed a packet");

    AST_LEN_RESERVED: assert property (
        ce && (sel_q[1].len == 3'h5 || sel_q[1].len == 3'h6) |=> !ev_q[1].hit
    ) else $error("reserved length code matched");

    AST_LEN_EXACT: assert property (
        $past(ce) && ev_q[0].hit && $past(sel_q[0].len) != PEF_LEN_ANY |->
            $past(sel_q[0].len) == $past(pkt.len)
    ) else $error("length mismatch gave a hit");

    AST_ATTR_EXACT: assert property (
        $past(ce) && ev_q[1].hit && $past(sel_q[1].attr) != PEF_ATTR_ANY |->
            $past(sel_q[1].attr) == $past(pkt.attr)
    ) else $error("attribute mismatch gave a hit");

    AST_SRC_EXACT: assert property (
        $past(ce) && ev_q[0].hit && $past(sel_q[0].src) != PEF_SRC_ANY |->
            $past(sel_q[0].src) == $past(pkt.src)
    ) else $error("source node mismatch gave a hit");

    AST_TYPE_MASKED: assert property (
        $past(ce) && ev_q[1].hit |->
            (($past(pkt.ptype) ^ $past(sel_q[1].tdata)) & ~$past(sel_q[1].tmask)) == 7'h00
    ) else $error("unmasked type bit differs on a hit");

    AST_TYPE_FIELDS: assert property (
        ce && pkt_valid && sel_q[0].tmask == 7'h00 && pkt.ptype != sel_q[0].tdata
        |=> !ev_q[0].hit
    ) else $error("type pattern mismatch gave a hit");

    AST_LEN_ACCUM: assert property (
        $past(ce) && ev_q[0].hit && $past(count_mode0) == PEF_MODE_LENGTH |->
            ev_q[0].inc == 8'(PEF_LEN_UNIT << $past(pkt.len))
    ) else $error("length mode increment wrong");

    AST_INC_ONE: assert property (
        $past(ce) && ev_q[1].hit && $past(count_mode1) != PEF_MODE_LENGTH |->
            ev_q[1].inc == PEF_INC_ONE
    ) else $error("event mode increment not one");

    AST_SEL_WRITE: assert property (
        ce && access && pwrite && paddr == PEF_OFS_SEL0 && pstrb == 4'hF |=>
            sel_q[0] == pef_sel_t'($past(pwdata) & PEF_SEL_WMASK)
    ) else $error("select write not stored");

    AST_UNMAPPED_ERR: assert property (
        ce && access && !mapped |-> pready && pslverr
    ) else $error("unmapped access not flagged");

endmodule
`default_nettype wire

// File: rtl/pef_pkg.sv
/*
 * pef_pkg: constants, register map and carrier types for the packet event filter.
 * assumes a single pclk domain; packets arrive from logic on the same clock.
 */
package pef_pkg;

    // register byte offsets
    localparam logic [11:0] PEF_OFS_SEL0 = 12'h0EC;
    localparam logic [11:0] PEF_OFS_SEL1 = 12'h0FC;
    localparam logic [11:0] PEF_OFS_HITS = 12'h100;
    localparam logic [11:0] PEF_OFS_LAST = 12'h104;

    // select register field positions
    localparam int PEF_LEN_HI = 27;
    localparam int PEF_LEN_LO = 25;
    localparam int PEF_ATTR_HI = 24;
    localparam int PEF_ATTR_LO = 21;
    localparam int PEF_SRC_HI = 20;
    localparam int PEF_SRC_LO = 16;
    localparam int PEF_PORT0_BIT = 14;
    localparam int PEF_PORT1_BIT = 15;
    localparam int PEF_TYPE_HI = 13;
    localparam int PEF_TYPE_LO = 7;
    localparam int PEF_MASK_HI = 6;
    localparam int PEF_MASK_LO = 0;

    // reset values and writable bits
    localparam logic [31:0] PEF_SEL_RESET = 32'h0000_0000;
    localparam logic [31:0] PEF_SEL_WMASK = 32'h0FFF_FFFF;

    // length codes and match-all values
    localparam logic [2:0] PEF_LEN_ANY = 3'h7;
    localparam logic [2:0] PEF_LEN_MAX = 3'h4;
    localparam logic [3:0] PEF_ATTR_ANY = 4'hF;
    localparam logic [4:0] PEF_SRC_ANY = 5'h1F;
    localparam logic [6:0] PEF_MASK_ALL = 7'h7F;

    // counter count mode that accumulates length
    localparam logic [1:0] PEF_MODE_LENGTH = 2'h2;
    localparam logic [7:0] PEF_INC_ONE = 8'h01;
    localparam logic [7:0] PEF_LEN_UNIT = 8'h08;

    // select register layout
    typedef struct packed {
        logic [3:0] rsvd;
        logic [2:0] len;
        logic [3:0] attr;
        logic [4:0] src;
        logic [1:0] port;
        logic [6:0] tdata;
        logic [6:0] tmask;
    } pef_sel_t;

    // received packet header as seen by the filter
    typedef struct packed {
        logic resp;
        logic port;
        logic [2:0] len;
        logic [3:0] attr;
        logic [4:0] src;
        logic [6:0] ptype;
    } pef_pkt_t;

    // event handed to one performance counter
    typedef struct packed {
        logic hit;
        logic [7:0] inc;
    } pef_ev_t;

endpackage

// File: rtl/pef_match.sv
/*
 * pef_match: combinational match of one packet header against one select register.
 * assumes the caller qualifies the result with its packet valid strobe.
 */
`timescale 1ns/1ps
`default_nettype none
module pef_match
    import pef_pkg::*;
(
    // programmed criteria
    input wire pef_sel_t sel,
    // packet header
    input wire pef_pkt_t pkt,
    // result
    output logic match
);
    logic len_ok;
    logic attr_ok;
    logic src_ok;
    logic port_ok;
    logic type_ok;

    always_comb begin
        // reserved codes 101 and 110 never match any packet
        len_ok = (sel.len == PEF_LEN_ANY) ||
                 ((sel.len <= PEF_LEN_MAX) && (sel.len == pkt.len));
        attr_ok = (sel.attr == PEF_ATTR_ANY) || (sel.attr == pkt.attr);
        src_ok = (sel.src == PEF_SRC_ANY) || (sel.src == pkt.src);
        // port bits are alternatives: either enabled port satisfies the group
        port_ok = pkt.port ? sel.port[1] : sel.port[0];
        // requests and responses share one bit layout, so one compare serves both
        type_ok = (((pkt.ptype ^ sel.tdata) & ~sel.tmask) == 7'h00);
        match = len_ok && attr_ok && src_ok && port_ok && type_ok;
    end

endmodule
`default_nettype wire

// File: verif/pef_pkt_src.sv
/*
 * pef_pkt_src: far side model, a port switch or io hub handing received packets in.
 * assumes the caller enters send just after a rising pclk edge.
 */
`timescale 1ns/1ps
`default_nettype none
module pef_pkt_src
    import pef_pkg::*;
(
    // clock
    input wire logic pclk,
    // packet lines
    output logic pkt_valid,
    output pef_pkt_t pkt
);
    initial begin
        pkt_valid = 1'b0;
        pkt = '0;
    end
    // requests and responses alike, one per cycle, back to back when keep is set
    task automatic send(input pef_pkt_t p, input logic keep);
        pkt_valid <= 1'b1;
        pkt <= p;
        @(posedge pclk);
        // released lines show the inverse so a stale header cannot pass for a packet
        if (!keep) begin
            pkt_valid <= 1'b0;
            pkt <= ~p;
        end
    endtask
endmodule
`default_nettype wire

// File: verif/pef_top_test.sv
/*
 * pef_top_test: self-checking bench for the two packet event filters.
 * assumes zero-wait apb answers and events one edge after the packet.
 */
`timescale 1ns/1ps
`default_nettype none
module pef_top_test
    import pef_pkg::*;
;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, pkt_valid, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] count_mode0, count_mode1;
    pef_pkt_t pkt;
    pef_ev_t ev0, ev1;
    int err_total = 0;
    int checks = 0;
    localparam pef_ev_t HIT1 = '{hit: 1'b1, inc: PEF_INC_ONE};

    pef_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt(pkt),
        .count_mode0(count_mode0), .count_mode1(count_mode1), .ev0(ev0), .ev1(ev1));
    pef_pkt_src i_src (.pclk(pclk), .pkt_valid(pkt_valid), .pkt(pkt));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_ev(input pef_ev_t got, input pef_ev_t exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // the request stands until pready is seen at an edge; only a bounded wait
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (n >= 20) begin
            err_total++;
            complete_run();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] sel(input logic [2:0] l, input logic [3:0] a,
        input logic [4:0] s, input logic [1:0] p, input logic [6:0] td, input logic [6:0] tm);
        return {4'h0, l, a, s, p, td, tm};
    endfunction

    function automatic pef_pkt_t pk(input logic r, input logic p, input logic [2:0] l,
        input logic [3:0] a, input logic [4:0] s, input logic [6:0] t);
        return {r, p, l, a, s, t};
    endfunction

    task automatic go(input pef_pkt_t p, input logic keep, input pef_ev_t e0, input pef_ev_t e1);
        i_src.send(p, keep);
        #1;
        chk_ev(ev0, e0);
        chk_ev(ev1, e1);
    endtask

    task automatic t_reset();
        apb(1'b0, PEF_OFS_SEL0, 32'h0);
        chk_w(rd, PEF_SEL_RESET);
        apb(1'b0, PEF_OFS_SEL1, 32'h0);
        chk_w(rd, PEF_SEL_RESET);
        apb(1'b0, 12'h0F0, 32'h0);
        chk_w({31'h0, er}, 32'h1);
        go(pk(0, 0, 3'h3, 4'h5, 5'h02, 7'h11), 0, '0, '0);
        $display("test reset done");
    endtask

    task automatic t_any();
        apb(1'b1, PEF_OFS_SEL0, sel(PEF_LEN_ANY, PEF_ATTR_ANY, PEF_SRC_ANY, 2'h3, 7'h00, 7'h7F));
        apb(1'b1, PEF_OFS_HITS, 32'h0);
        go(pk(0, 0, 3'h0, 4'h1, 5'h03, 7'h55), 1, HIT1, '0);
        go(pk(1, 1, 3'h2, 4'h9, 5'h1E, 7'h2A), 1, HIT1, '0);
        go(pk(0, 1, 3'h4, 4'h3, 5'h10, 7'h7F), 0, HIT1, '0);
        @(posedge pclk);
        #1;
        chk_ev(ev0, '0);
        apb(1'b0, PEF_OFS_HITS, 32'h0);
        chk_w(rd, 32'h0000_0003);
        $display("test any done");
    endtask

    task automatic t_type();
        apb(1'b1, PEF_OFS_SEL0, sel(3'h7, 4'hF, 5'h1F, 2'h3, 7'b1010_01_1, 7'b0000_011));
        go(pk(0, 0, 3'h1, 4'h0, 5'h00, 7'b1010_00_0), 1, HIT1, '0);
        go(pk(1, 0, 3'h1, 4'h0, 5'h00, 7'b1010_01_0), 1, HIT1, '0);
        go(pk(0, 0, 3'h1, 4'h0, 5'h00, 7'b0010_01_1), 1, '0, '0);
        go(pk(1, 1, 3'h1, 4'h0, 5'h00, 7'b1010_11_1), 0, '0, '0);
        apb(1'b1, PEF_OFS_SEL0, sel(3'h7, 4'hF, 5'h1F, 2'h3, 7'b1010_01_1, 7'h00));
        go(pk(0, 0, 3'h1, 4'h0, 5'h00, 7'b1010_01_0), 1, '0, '0);
        go(pk(0, 0, 3'h1, 4'h0, 5'h00, 7'b1010_01_1), 0, HIT1, '0);
        $display("test type done");
    endtask

    task automatic t_fields();
        apb(1'b1, PEF_OFS_SEL0, sel(3'h3, 4'h5, 5'h0A, 2'b01, 7'h00, 7'h7F));
        go(pk(0, 0, 3'h3, 4'h5, 5'h0A, 7'h00), 1, HIT1, '0);
        go(pk(0, 0, 3'h3, 4'h6, 5'h0A, 7'h00), 1, '0, '0);
        go(pk(0, 0, 3'h3, 4'h5, 5'h0B, 7'h00), 1, '0, '0);
        go(pk(0, 1, 3'h3, 4'h5, 5'h0A, 7'h00), 1, '0, '0);
        go(pk(0, 0, 3'h2, 4'h5, 5'h0A, 7'h00), 0, '0, '0);
        apb(1'b1, PEF_OFS_SEL0, sel(3'h3, 4'h5, 5'h0A, 2'b10, 7'h00, 7'h7F));
        go(pk(1, 1, 3'h3, 4'h5, 5'h0A, 7'h00), 1, HIT1, '0);
        go(pk(1, 0, 3'h3, 4'h5, 5'h0A, 7'h00), 0, '0, '0);
        $display("test fields done");
    endtask

    task automatic t_len();
        apb(1'b1, PEF_OFS_SEL0, sel(3'h7, 4'hF, 5'h1F, 2'h3, 7'h00, 7'h7F));
        count_mode1 <= PEF_MODE_LENGTH;
        for (int c = 0; c < 5; c++) begin
            apb(1'b1, PEF_OFS_SEL1, sel(3'(c), 4'hF, 5'h1F, 2'h3, 7'h00, 7'h7F));
            go(pk(0, 0, 3'(c), 4'h0, 5'h00, 7'h00), 1, HIT1, '{1'b1, 8'(PEF_LEN_UNIT << c)});
            go(pk(1, 1, 3'((c + 1) % 5), 4'h0, 5'h00, 7'h00), 0, HIT1, '0);
        end
        // reserved length codes never match, whatever the packet carries
        for (int c = 5; c < 7; c++) begin
            apb(1'b1, PEF_OFS_SEL1, sel(3'(c), 4'hF, 5'h1F, 2'h3, 7'h00, 7'h7F));
            for (int l = 0; l < 5; l++)
                go(pk(0, 0, 3'(l), 4'h0, 5'h00, 7'h00), 0, HIT1, '0);
        end
        $display("test length done");
    endtask

    task automatic t_misc();
        apb(1'b0, PEF_OFS_LAST, 32'h0);
        chk_w(rd, 32'(pk(0, 0, 3'h4, 4'h0, 5'h00, 7'h00)));
        count_mode0 <= PEF_MODE_LENGTH;
        go(pk(0, 0, 3'h3, 4'h0, 5'h00, 7'h00), 0, '{1'b1, 8'h40}, '0);
        // frozen enable holds the pulse and ignores the packet
        ce <= 1'b0;
        go(pk(0, 0, 3'h1, 4'h0, 5'h00, 7'h00), 0, '{1'b1, 8'h40}, '0);
        ce <= 1'b1;
        count_mode0 <= 2'h0;
        @(posedge pclk);
        #1;
        chk_ev(ev0, '0);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PEF_OFS_SEL0, 32'h0);
        chk_w(rd, PEF_SEL_RESET);
        $display("test misc done");
    endtask

    initial begin
        presetn = 1'b0;
        ce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hF;
        count_mode0 = 2'h0;
        count_mode1 = 2'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_any();
        t_type();
        t_fields();
        t_len();
        t_misc();
        complete_run();
    end

    initial begin
        #1000000;
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
